// ### core/err_info_consts.vh
`ifndef ERR_INFO_CONSTS_VH
`define ERR_INFO_CONSTS_VH
`define OFS_IRQ_ENABLE          12'h500
`define OFS_IRQ_CLEAR           12'h508
`define OFS_IRQ_STATUS          12'h510
`define OFS_IRQ_MASK            12'h514
`define OFS_RAM_UNCORR_HIGH     12'h524
`define OFS_DRAM_CORR_LOW       12'h528
`define OFS_DRAM_CORR_HIGH      12'h52C
`define OFS_DRAM_UNCORR_LOW     12'h530
`define OFS_DRAM_UNCORR_HIGH    12'h534
`define OFS_BAD_ACCESS_LOW      12'h538
`define OFS_BAD_ACCESS_HIGH     12'h53C
`define OFS_BAD_REGPORT_LOW     12'h540
`define OFS_BAD_REGPORT_HIGH    12'h544
`define SRC_RAM_UNCORR          1
`define SRC_DRAM_CORR           2
`define SRC_DRAM_UNCORR         3
`define SRC_BAD_ACCESS          4
`define SRC_BAD_REGPORT         5
`define NUM_SRC                 6
`define OFLOW_POS               16
`define LOW_VALID_POS           0
`define HIGH_VALID_POS          31
`define DBID_HI                 10
`define DBID_LO                 4
`define BANK_HI                 3
`define BANK_LO                 0
`define RANK_HI                 31
`define RANK_LO                 29
`define ROW_HI                  28
`define ROW_LO                  11
`define COL_HI                  10
`define COL_LO                  1
`define LOC_VALID_HI            27
`define LOC_VALID_LO            24
`define NIBBLE_HI               23
`define NIBBLE_LO               4
`define MASKED_RANK_POS         22
`define UNMAPPED_POS            21
`define SEC_FAIL_POS            20
`define OUTSIDE_POS             19
`define REGION_HI               18
`define REGION_LO               10
`define WRITE_POS               9
`define NONSECURE_POS           8
`define SOURCE_ID_HI            7
`define SOURCE_ID_LO            1
`define REGPORT_ADDR_HI         13
`define REGPORT_ADDR_LO         1
`define RESET_WORD              32'h00000000
`define RESP_OKAY               2'h0
`define RESP_SLVERR             2'h2
`endif

// ### core/error_interrupt_info_capture.v
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "err_info_consts.vh"
module error_interrupt_info_capture (
    input  wire        i_sys_clk,
    input  wire        i_reset_n,
    input  wire [11:0] i_awaddr,
    input  wire        i_awvalid,
    output reg         o_awready,
    input  wire [31:0] i_wdata,
    input  wire [3:0]  i_wstrb,
    input  wire        i_wvalid,
    output reg         o_wready,
    output reg  [1:0]  o_bresp,
    output reg         o_bvalid,
    input  wire        i_bready,
    input  wire [11:0] i_araddr,
    input  wire        i_arvalid,
    output reg         o_arready,
    output reg  [31:0] o_rdata,
    output reg  [1:0]  o_rresp,
    output reg         o_rvalid,
    input  wire        i_rready,
    input  wire        i_ram_uncorr_event,
    input  wire [6:0]  i_ram_uncorr_buffer_id,
    input  wire [3:0]  i_ram_uncorr_bank,
    input  wire        i_dram_corr_event,
    input  wire [2:0]  i_dram_corr_rank,
    input  wire [17:0] i_dram_corr_row,
    input  wire [9:0]  i_dram_corr_column,
    input  wire [3:0]  i_dram_corr_bank,
    input  wire [19:0] i_dram_corr_nibble_loc,
    input  wire [3:0]  i_dram_corr_loc_valid,
    input  wire        i_dram_uncorr_event,
    input  wire [2:0]  i_dram_uncorr_rank,
    input  wire [17:0] i_dram_uncorr_row,
    input  wire [9:0]  i_dram_uncorr_column,
    input  wire [3:0]  i_dram_uncorr_bank,
    input  wire        i_bad_access_event,
    input  wire        i_hit_masked_rank,
    input  wire        i_unmapped,
    input  wire        i_security_check_failed,
    input  wire        i_outside_default,
    input  wire [8:0]  i_region,
    input  wire        i_is_write,
    input  wire        i_access_nonsecure,
    input  wire [6:0]  i_source_id,
    input  wire        i_bad_regport_event,
    input  wire [12:0] i_regport_addr,
    output reg         o_irq
);

    reg  [`NUM_SRC-1:0] pending;
    reg  [`NUM_SRC-1:0] overflow;
    reg  [`NUM_SRC-1:0] enable;
    reg  [`NUM_SRC-1:0] mask;
    reg  [31:0]         ram_uncorrected_info_high;
    reg  [31:0]         dram_corrected_info_low;
    reg  [31:0]         dram_corrected_info_high;
    reg  [31:0]         dram_uncorrected_info_low;
    reg  [31:0]         dram_uncorrected_info_high;
    reg  [31:0]         bad_access_info_low;
    reg  [31:0]         bad_access_info_high;
    reg  [31:0]         bad_regport_info_low;
    reg  [31:0]         bad_regport_info_high;
    reg  [11:0]         aw_addr;
    reg                 aw_held;
    reg  [31:0]         w_data;
    reg  [3:0]          w_strb;
    reg                 w_held;
    reg  [31:0]         next_rdata;
    reg  [1:0]          next_rresp;
    reg                 wr_known;
    reg  [31:0]         next_ram_uncorr_high;
    reg  [31:0]         next_corr_low;
    reg  [31:0]         next_corr_high;
    reg  [31:0]         next_uncorr_low;
    reg  [31:0]         next_uncorr_high;
    reg  [31:0]         next_access_low;
    reg  [31:0]         next_access_high;
    reg  [31:0]         next_regport_low;
    reg  [31:0]         next_regport_high;
    wire [`NUM_SRC-1:0] event_in;
    wire [`NUM_SRC-1:0] clear_bits;
    wire [`NUM_SRC-1:0] load;
    wire                wr_fire;
    wire                rd_fire;

    // Corrected on-chip RAM source has no words in this bank; its event is tied off
    assign event_in = {i_bad_regport_event, i_bad_access_event, i_dram_uncorr_event,
                       i_dram_corr_event, i_ram_uncorr_event, 1'b0};

    assign wr_fire = aw_held && w_held && !o_bvalid;
    assign rd_fire = i_arvalid && o_arready;
    assign clear_bits = (wr_fire && aw_addr == `OFS_IRQ_CLEAR && w_strb[0])
                        ? w_data[`NUM_SRC-1:0] : {`NUM_SRC{1'b0}};
    assign load = event_in & ~pending;

    genvar g;
    generate
        for (g = 0; g < `NUM_SRC; g = g + 1) begin : g_src
            // Event beats a clear in the same cycle
            always @(posedge i_sys_clk) begin
                if (!i_reset_n) begin
                    pending[g] <= 1'b0;
                end else if (event_in[g]) begin
                    pending[g] <= 1'b1;
                end else if (clear_bits[g]) begin
                    pending[g] <= 1'b0;
                end
            end

            // Clear drops overflow so the kept capture reads valid again
            always @(posedge i_sys_clk) begin
                if (!i_reset_n) begin
                    overflow[g] <= 1'b0;
                end else if (event_in[g] && pending[g] && !clear_bits[g]) begin
                    overflow[g] <= 1'b1;
                end else if (clear_bits[g]) begin
                    overflow[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // Words are built field by field; anything not named stays zero
    always @* begin
        next_ram_uncorr_high = `RESET_WORD;
        next_ram_uncorr_high[`HIGH_VALID_POS] = 1'b1;
        next_ram_uncorr_high[`DBID_HI:`DBID_LO] = i_ram_uncorr_buffer_id;
        next_ram_uncorr_high[`BANK_HI:`BANK_LO] = i_ram_uncorr_bank;
        next_corr_low = `RESET_WORD;
        next_corr_low[`LOW_VALID_POS] = 1'b1;
        next_corr_low[`RANK_HI:`RANK_LO] = i_dram_corr_rank;
        next_corr_low[`ROW_HI:`ROW_LO] = i_dram_corr_row;
        next_corr_low[`COL_HI:`COL_LO] = i_dram_corr_column;
        next_corr_high = `RESET_WORD;
        next_corr_high[`HIGH_VALID_POS] = 1'b1;
        next_corr_high[`LOC_VALID_HI:`LOC_VALID_LO] = i_dram_corr_loc_valid;
        next_corr_high[`NIBBLE_HI:`NIBBLE_LO] = i_dram_corr_nibble_loc;
        next_corr_high[`BANK_HI:`BANK_LO] = i_dram_corr_bank;
        next_uncorr_low = `RESET_WORD;
        next_uncorr_low[`LOW_VALID_POS] = 1'b1;
        next_uncorr_low[`RANK_HI:`RANK_LO] = i_dram_uncorr_rank;
        next_uncorr_low[`ROW_HI:`ROW_LO] = i_dram_uncorr_row;
        next_uncorr_low[`COL_HI:`COL_LO] = i_dram_uncorr_column;
        next_uncorr_high = `RESET_WORD;
        next_uncorr_high[`HIGH_VALID_POS] = 1'b1;
        next_uncorr_high[`BANK_HI:`BANK_LO] = i_dram_uncorr_bank;
        next_access_low = `RESET_WORD;
        next_access_low[`LOW_VALID_POS] = 1'b1;
        next_access_low[`MASKED_RANK_POS] = i_hit_masked_rank;
        next_access_low[`UNMAPPED_POS] = i_unmapped;
        next_access_low[`SEC_FAIL_POS] = i_security_check_failed;
        next_access_low[`OUTSIDE_POS] = i_outside_default;
        next_access_low[`REGION_HI:`REGION_LO] = i_region;
        next_access_low[`WRITE_POS] = i_is_write;
        next_access_low[`NONSECURE_POS] = i_access_nonsecure;
        next_access_low[`SOURCE_ID_HI:`SOURCE_ID_LO] = i_source_id;
        next_access_high = `RESET_WORD;
        next_access_high[`HIGH_VALID_POS] = 1'b1;
        next_regport_low = `RESET_WORD;
        next_regport_low[`LOW_VALID_POS] = 1'b1;
        next_regport_low[`REGPORT_ADDR_HI:`REGPORT_ADDR_LO] = i_regport_addr;
        next_regport_high = `RESET_WORD;
        next_regport_high[`HIGH_VALID_POS] = 1'b1;
    end

    // Capture logic is the only writer of info words
    always @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            ram_uncorrected_info_high  <= `RESET_WORD;
            dram_corrected_info_low    <= `RESET_WORD;
            dram_corrected_info_high   <= `RESET_WORD;
            dram_uncorrected_info_low  <= `RESET_WORD;
            dram_uncorrected_info_high <= `RESET_WORD;
            bad_access_info_low        <= `RESET_WORD;
            bad_access_info_high       <= `RESET_WORD;
            bad_regport_info_low       <= `RESET_WORD;
            bad_regport_info_high      <= `RESET_WORD;
        end else begin
            if (load[`SRC_RAM_UNCORR])
                ram_uncorrected_info_high <= next_ram_uncorr_high;
            if (load[`SRC_DRAM_CORR]) begin
                dram_corrected_info_low  <= next_corr_low;
                dram_corrected_info_high <= next_corr_high;
            end
            if (load[`SRC_DRAM_UNCORR]) begin
                dram_uncorrected_info_low  <= next_uncorr_low;
                dram_uncorrected_info_high <= next_uncorr_high;
            end
            if (load[`SRC_BAD_ACCESS]) begin
                bad_access_info_low  <= next_access_low;
                bad_access_info_high <= next_access_high;
            end
            if (load[`SRC_BAD_REGPORT]) begin
                bad_regport_info_low  <= next_regport_low;
                bad_regport_info_high <= next_regport_high;
            end
        end
    end

    // Ready drops after a handshake so each channel holds one item at most
    always @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            o_awready <= 1'b0;
            o_wready  <= 1'b0;
        end else begin
            o_awready <= !aw_held && !(i_awvalid && o_awready) && !o_bvalid;
            o_wready  <= !w_held && !(i_wvalid && o_wready) && !o_bvalid;
        end
    end

    // Software-owned enable and mask bits
    always @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            enable <= {`NUM_SRC{1'b0}};
            mask   <= {`NUM_SRC{1'b0}};
        end else if (wr_fire && w_strb[0]) begin
            if (aw_addr == `OFS_IRQ_ENABLE)
                enable <= w_data[`NUM_SRC-1:0];
            if (aw_addr == `OFS_IRQ_MASK)
                mask <= w_data[`NUM_SRC-1:0];
        end
    end

    // Write channel: address and data accepted in either order
    always @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            aw_addr   <= 12'h000;
            aw_held   <= 1'b0;
            w_data    <= 32'h00000000;
            w_strb    <= 4'h0;
            w_held    <= 1'b0;
            o_bvalid  <= 1'b0;
            o_bresp   <= `RESP_OKAY;
        end else begin
            if (i_awvalid && o_awready) begin
                aw_addr <= i_awaddr;
                aw_held <= 1'b1;
            end
            if (i_wvalid && o_wready) begin
                w_data <= i_wdata;
                w_strb <= i_wstrb;
                w_held <= 1'b1;
            end
            if (wr_fire) begin
                aw_held  <= 1'b0;
                w_held   <= 1'b0;
                o_bvalid <= 1'b1;
                o_bresp  <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
            end else if (o_bvalid && i_bready) begin
                o_bvalid <= 1'b0;
            end
        end
    end

    // Info words accept writes silently with OKAY; the data is dropped
    always @* begin
        case (aw_addr)
            `OFS_IRQ_ENABLE,
            `OFS_IRQ_CLEAR,
            `OFS_IRQ_MASK,
            `OFS_IRQ_STATUS,
            `OFS_RAM_UNCORR_HIGH,
            `OFS_DRAM_CORR_LOW,
            `OFS_DRAM_CORR_HIGH,
            `OFS_DRAM_UNCORR_LOW,
            `OFS_DRAM_UNCORR_HIGH,
            `OFS_BAD_ACCESS_LOW,
            `OFS_BAD_ACCESS_HIGH,
            `OFS_BAD_REGPORT_LOW,
            `OFS_BAD_REGPORT_HIGH: wr_known = 1'b1;
            default: wr_known = 1'b0;
        endcase
    end

    // Valid bit is gated by overflow at read time
    always @* begin
        next_rresp = `RESP_OKAY;
        case (i_araddr)
            `OFS_IRQ_ENABLE:  next_rdata = {26'h0000000, enable};
            `OFS_IRQ_MASK:    next_rdata = {26'h0000000, mask};
            `OFS_IRQ_STATUS:  next_rdata = {10'h000, overflow, 10'h000, pending};
            `OFS_RAM_UNCORR_HIGH:
                next_rdata = ram_uncorrected_info_high &
                             {~overflow[`SRC_RAM_UNCORR], 31'h7FFFFFFF};
            `OFS_DRAM_CORR_LOW:
                next_rdata = dram_corrected_info_low &
                             {31'h7FFFFFFF, ~overflow[`SRC_DRAM_CORR]};
            `OFS_DRAM_CORR_HIGH:
                next_rdata = dram_corrected_info_high &
                             {~overflow[`SRC_DRAM_CORR], 31'h7FFFFFFF};
            `OFS_DRAM_UNCORR_LOW:
                next_rdata = dram_uncorrected_info_low &
                             {31'h7FFFFFFF, ~overflow[`SRC_DRAM_UNCORR]};
            `OFS_DRAM_UNCORR_HIGH:
                next_rdata = dram_uncorrected_info_high &
                             {~overflow[`SRC_DRAM_UNCORR], 31'h7FFFFFFF};
            `OFS_BAD_ACCESS_LOW:
                next_rdata = bad_access_info_low &
                             {31'h7FFFFFFF, ~overflow[`SRC_BAD_ACCESS]};
            `OFS_BAD_ACCESS_HIGH:
                next_rdata = bad_access_info_high &
                             {~overflow[`SRC_BAD_ACCESS], 31'h7FFFFFFF};
            `OFS_BAD_REGPORT_LOW:
                next_rdata = bad_regport_info_low &
                             {31'h7FFFFFFF, ~overflow[`SRC_BAD_REGPORT]};
            `OFS_BAD_REGPORT_HIGH:
                next_rdata = bad_regport_info_high &
                             {~overflow[`SRC_BAD_REGPORT], 31'h7FFFFFFF};
            `OFS_IRQ_CLEAR: next_rdata = 32'h00000000;
            default: begin
                next_rdata = 32'h00000000;
                next_rresp = `RESP_SLVERR;
            end
        endcase
    end

    always @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            o_arready <= 1'b0;
        end else begin
            o_arready <= !o_rvalid && !rd_fire;
        end
    end

    // Read answer holds until the master takes it
    always @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            o_rvalid  <= 1'b0;
            o_rdata   <= 32'h00000000;
            o_rresp   <= `RESP_OKAY;
        end else begin
            if (rd_fire) begin
                o_rvalid <= 1'b1;
                o_rdata  <= next_rdata;
                o_rresp  <= next_rresp;
            end else if (o_rvalid && i_rready) begin
                o_rvalid <= 1'b0;
            end
        end
    end

    // Registered level; follows pending & enable & mask one cycle late
    always @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(pending & enable & mask);
        end
    end

endmodule // error_interrupt_info_capture

// ### tb/err_info_checker_sva.sv
`timescale 1ns/10ps
`include "err_info_consts.vh"
module err_info_checker (
    input wire        i_sys_clk,
    input wire        i_reset_n,
    input wire [11:0] i_araddr,
    input wire        i_arvalid,
    input wire        o_arready,
    input wire [31:0] o_rdata,
    input wire [1:0]  o_rresp,
    input wire        o_rvalid,
    input wire        i_rready,
    input wire        o_awready,
    input wire        o_wready,
    input wire [1:0]  o_bresp,
    input wire        o_bvalid,
    input wire        i_bready,
    input wire        o_irq
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);

    sequence ar_at(logic [11:0] a);
        i_arvalid && o_arready && i_araddr == a;
    endsequence

    a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
        else $error("read not answered in the next cycle");
    a_rdata_stable: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
        else $error("read data moved before being taken");
    a_bresp_stable: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
        else $error("write response moved before being taken");
    a_read_refused: assert property (o_rvalid |-> !o_arready)
        else $error("read address accepted while a read is open");
    a_write_refused: assert property (o_bvalid |-> !o_awready && !o_wready)
        else $error("write accepted while a response is open");
    a_irq_after_reset: assert property ($rose(i_reset_n) |-> !o_irq ##1 !o_irq)
        else $error("interrupt raised straight out of reset");
    a_unmapped_err: assert property (ar_at(12'hFFC) |=>
        o_rresp == `RESP_SLVERR && o_rdata == `RESET_WORD)
        else $error("unmapped read not refused");
    a_access_high_zero: assert property (ar_at(`OFS_BAD_ACCESS_HIGH) |=>
        o_rdata[30:0] == 31'h0)
        else $error("failed access high word reserved bits set");
    a_dram_high_zero: assert property (ar_at(`OFS_DRAM_UNCORR_HIGH) |=>
        o_rdata[30:4] == 27'h0)
        else $error("uncorrected high word reserved bits set");
    a_ram_high_okay: assert property (ar_at(`OFS_RAM_UNCORR_HIGH) |=>
        o_rresp == `RESP_OKAY && o_rdata[30:11] == 20'h0)
        else $error("ram high word read refused or reserved bits set");
endmodule // err_info_checker

bind error_interrupt_info_capture err_info_checker u_chk (
    .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_araddr(i_araddr),
    .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp),
    .o_rvalid(o_rvalid), .i_rready(i_rready), .o_awready(o_awready), .o_wready(o_wready),
    .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready), .o_irq(o_irq));

// ### tb/tb_top.sv
`timescale 1ns/10ps
`include "err_info_consts.vh"
module tb_top;
    logic        i_sys_clk, i_reset_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
    logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq;
    logic [11:0] i_awaddr, i_araddr;
    logic [31:0] i_wdata, o_rdata;
    logic [3:0]  i_wstrb, i_dram_corr_bank, i_dram_corr_loc_valid;
    logic [1:0]  o_bresp, o_rresp;
    logic [5:1]  ev;
    logic [6:0]  i_ram_uncorr_buffer_id, i_source_id;
    logic [2:0]  i_dram_corr_rank;
    logic [17:0] i_dram_corr_row;
    logic [9:0]  i_dram_corr_column;
    logic [19:0] i_dram_corr_nibble_loc;
    logic        i_hit_masked_rank, i_unmapped, i_security_check_failed, i_outside_default;
    logic        i_is_write, i_access_nonsecure;
    logic [8:0]  i_region;
    logic [12:0] i_regport_addr;
    int          bad_count = 0;
    int          comparisons = 0;

    // All three ecc sources share payload wires to keep the bench small
    error_interrupt_info_capture dut (
        .i_sys_clk, .i_reset_n, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb,
        .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid,
        .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready,
        .i_ram_uncorr_event(ev[`SRC_RAM_UNCORR]), .i_ram_uncorr_buffer_id,
        .i_ram_uncorr_bank(i_dram_corr_bank), .i_dram_corr_event(ev[`SRC_DRAM_CORR]),
        .i_dram_corr_rank, .i_dram_corr_row, .i_dram_corr_column, .i_dram_corr_bank,
        .i_dram_corr_nibble_loc, .i_dram_corr_loc_valid,
        .i_dram_uncorr_event(ev[`SRC_DRAM_UNCORR]), .i_dram_uncorr_rank(i_dram_corr_rank),
        .i_dram_uncorr_row(i_dram_corr_row), .i_dram_uncorr_column(i_dram_corr_column),
        .i_dram_uncorr_bank(i_dram_corr_bank), .i_bad_access_event(ev[`SRC_BAD_ACCESS]),
        .i_hit_masked_rank, .i_unmapped, .i_security_check_failed, .i_outside_default,
        .i_region, .i_is_write, .i_access_nonsecure, .i_source_id,
        .i_bad_regport_event(ev[`SRC_BAD_REGPORT]), .i_regport_addr, .o_irq);

    initial begin
        i_sys_clk = 1'b0;
        forever #20 i_sys_clk = ~i_sys_clk;
    end

    task automatic final_report;
        if (bad_count == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Each channel is released at the edge that takes it, never earlier
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        i_awaddr  <= a;
        i_wdata   <= d;
        i_awvalid <= 1'b1;
        i_wvalid  <= 1'b1;
        i_bready  <= 1'b1;
        do begin
            @(posedge i_sys_clk);
            if (o_awready) i_awvalid <= 1'b0;
            if (o_wready) i_wvalid <= 1'b0;
        end while (!o_bvalid);
        i_bready <= 1'b0;
        check(o_bresp, `RESP_OKAY);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        i_araddr  <= a;
        i_arvalid <= 1'b1;
        i_rready  <= 1'b1;
        do begin
            @(posedge i_sys_clk);
            if (o_arready) i_arvalid <= 1'b0;
        end while (!o_rvalid);
        i_rready <= 1'b0;
        check(o_rdata, e);
        check(o_rresp, er);
    endtask

    task automatic fire(input int k);
        ev[k] <= 1'b1;
        @(posedge i_sys_clk);
        ev <= '0;
        @(posedge i_sys_clk);
    endtask

    task automatic t_reset;
        for (int a = 'h524; a <= 'h544; a += 4)
            rd(a[11:0], `RESET_WORD, `RESP_OKAY);
        rd(`OFS_IRQ_STATUS, `RESET_WORD, `RESP_OKAY);
        rd(12'hFFC, `RESET_WORD, `RESP_SLVERR);
        wr(`OFS_IRQ_ENABLE, 32'h3E);
        rd(`OFS_IRQ_ENABLE, 32'h3E, `RESP_OKAY);
        wr(`OFS_IRQ_MASK, 32'h3E);
        check(o_irq, 1'b0);
    endtask

    task automatic t_access;
        logic [31:0] e1, e2;
        e1 = {9'h0, 4'hA, 9'h100, 2'b10, 7'h55, 1'b1};
        e2 = {9'h0, 4'h5, 9'h001, 2'b01, 7'h2A, 1'b1};
        {i_hit_masked_rank, i_unmapped, i_security_check_failed, i_outside_default,
            i_region, i_is_write, i_access_nonsecure, i_source_id} <= e1[22:1];
        fire(`SRC_BAD_ACCESS);
        rd(`OFS_BAD_ACCESS_LOW, e1, `RESP_OKAY);
        rd(`OFS_BAD_ACCESS_HIGH, 32'h80000000, `RESP_OKAY);
        check(o_irq, 1'b1);
        wr(`OFS_IRQ_MASK, 32'h2E);
        rd(`OFS_IRQ_STATUS, 32'h10, `RESP_OKAY);
        check(o_irq, 1'b0);
        wr(`OFS_IRQ_MASK, 32'h3E);
        {i_hit_masked_rank, i_unmapped, i_security_check_failed, i_outside_default,
            i_region, i_is_write, i_access_nonsecure, i_source_id} <= e2[22:1];
        fire(`SRC_BAD_ACCESS);
        rd(`OFS_BAD_ACCESS_LOW, e1 & ~32'h1, `RESP_OKAY);
        rd(`OFS_BAD_ACCESS_HIGH, 32'h0, `RESP_OKAY);
        rd(`OFS_IRQ_STATUS, 32'h00100010, `RESP_OKAY);
        wr(`OFS_IRQ_CLEAR, 32'h10);
        rd(`OFS_IRQ_STATUS, 32'h0, `RESP_OKAY);
        check(o_irq, 1'b0);
        fire(`SRC_BAD_ACCESS);
        rd(`OFS_BAD_ACCESS_LOW, e2, `RESP_OKAY);
        wr(`OFS_IRQ_CLEAR, 32'h10);
    endtask

    task automatic t_ecc;
        logic [31:0] lo;
        lo = {3'h5, 18'h2ABCD, 10'h3C5, 1'b1};
        i_ram_uncorr_buffer_id <= 7'h5A;
        i_dram_corr_bank <= 4'hC;
        {i_dram_corr_rank, i_dram_corr_row, i_dram_corr_column} <= lo[31:1];
        i_dram_corr_nibble_loc <= {5'd17, 5'd0, 5'd9, 5'd3};
        i_dram_corr_loc_valid <= 4'hB;
        for (int k = 1; k < 4; k++)
            fire(k);
        rd(`OFS_RAM_UNCORR_HIGH, {1'b1, 20'h0, 7'h5A, 4'hC}, `RESP_OKAY);
        rd(`OFS_DRAM_CORR_LOW, lo, `RESP_OKAY);
        rd(`OFS_DRAM_CORR_HIGH, {4'h8, 4'hB, 5'd17, 5'd0, 5'd9, 5'd3, 4'hC}, `RESP_OKAY);
        rd(`OFS_DRAM_UNCORR_LOW, lo, `RESP_OKAY);
        rd(`OFS_DRAM_UNCORR_HIGH, {1'b1, 27'h0, 4'hC}, `RESP_OKAY);
        wr(`OFS_IRQ_CLEAR, 32'hE);
    endtask

    task automatic t_regport;
        i_regport_addr <= 13'h1ABC;
        fire(`SRC_BAD_REGPORT);
        rd(`OFS_BAD_REGPORT_LOW, {18'h0, 13'h1ABC, 1'b1}, `RESP_OKAY);
        rd(`OFS_BAD_REGPORT_HIGH, 32'h80000000, `RESP_OKAY);
        wr(`OFS_BAD_REGPORT_LOW, 32'hFFFFFFFF);
        rd(`OFS_BAD_REGPORT_LOW, {18'h0, 13'h1ABC, 1'b1}, `RESP_OKAY);
        wr(`OFS_IRQ_STATUS, 32'hFFFFFFFF);
        rd(`OFS_IRQ_STATUS, 32'h20, `RESP_OKAY);
        wr(`OFS_IRQ_CLEAR, 32'h20);
        @(posedge i_sys_clk);
        check(o_irq, 1'b0);
    endtask

    initial begin
        {i_reset_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, ev} = '0;
        {i_awaddr, i_araddr, i_wdata, i_ram_uncorr_buffer_id, i_dram_corr_bank} = '0;
        {i_dram_corr_rank, i_dram_corr_row, i_dram_corr_column} = '0;
        {i_dram_corr_nibble_loc, i_dram_corr_loc_valid, i_region, i_source_id} = '0;
        {i_hit_masked_rank, i_unmapped, i_security_check_failed, i_outside_default} = '0;
        {i_is_write, i_access_nonsecure, i_regport_addr} = '0;
        i_wstrb = 4'hF;
        repeat (10) @(posedge i_sys_clk);
        i_reset_n <= 1'b1;
        repeat (2) @(posedge i_sys_clk);
        t_reset();
        t_access();
        t_ecc();
        t_regport();
        final_report();
    end

    // Whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge i_sys_clk);
        bad_count++;
        final_report();
    end
endmodule // tb_top
